// File: pkg/pcw_pkg.sv
// Package: register map, field layout, reset values and timing for the port config bank
package pcw_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [4:0] WPC_ADDR = 5'h12; // wake_power_config
    localparam logic [4:0] AQC_ADDR = 5'h13; // address_quality_config
    localparam logic [15:0] UNMAPPED_DATA = 16'h0000; // Answer to unknown offsets
    // ==========================================================
    // wake_power_config field positions
    localparam int WPC_LOC_FWD_BIT = 14;
    localparam int WPC_REM_REACT_BIT = 11;
    localparam int WPC_LOC_REACT_BIT = 10;
    localparam int WPC_REM_FWD_BIT = 2;
    localparam int WPC_PWD_BIT = 1;
    localparam int WPC_SLEEP_BIT = 0;
    // ==========================================================
    // address_quality_config field positions
    localparam int AQC_PA_MSB = 15;
    localparam int AQC_PA_LSB = 11;
    localparam int AQC_AVG_MSB = 10;
    localparam int AQC_AVG_LSB = 9;
    localparam int AQC_WARN_MSB = 8;
    localparam int AQC_WARN_LSB = 6;
    localparam int AQC_FAIL_MSB = 5;
    localparam int AQC_FAIL_LSB = 3;
    // ==========================================================
    // Reset values
    localparam logic PWD_RST = 1'b0;
    localparam logic SLEEP_EN_RST = 1'b1;
    localparam logic [1:0] AVG_RST = 2'h1;
    localparam logic [2:0] WARN_RST = 3'h1;
    localparam logic [2:0] FAIL_RST = 3'h0;
    localparam logic [2:0] NO_LIMIT = 3'h0; // Class code meaning no limit
    localparam logic [8:0] AVG_BASE_SYMBOLS = 9'h020; // Depth for code 00
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int WAKE_ACT_US = 50; // Wake-detection activation time
    localparam int WAKE_ACT_CYCLES = WAKE_ACT_US * CLK_MHZ;
    // Arming states of the local wake detector
    typedef enum logic [2:0] {
        PCW_OFF = 3'b001,
        PCW_ARMING = 3'b010,
        PCW_ARMED = 3'b100
    } pcw_arm_e;
endpackage : pcw_pkg

// File: logic/pcw_arm_timer.sv
// Activation timer that arms local wake detection after its enable rises
`timescale 1ns/100ps
`default_nettype none
module pcw_arm_timer #(
    parameter int COUNT = 2000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    output logic armed
);
    import pcw_pkg::*;
    localparam int CW = $clog2(COUNT + 1);
    // ==========================================================
    // Elaboration check
    if (COUNT < 4) begin : g_bad_count
        $error("pcw_arm_timer COUNT must be at least 4");
    end
    pcw_arm_e state_q; // Arming state
    logic [CW-1:0] cnt_q; // Cycles spent arming
    // Arming sequence; dropping the enable restarts it
    always_ff @(posedge sys_clk) begin
        if (rst || !enable) begin
            state_q <= PCW_OFF;
            cnt_q <= '0;
        end else begin
            case (state_q)
                PCW_OFF: begin
                    state_q <= PCW_ARMING;
                    cnt_q <= '0;
                end
                PCW_ARMING: begin
                    if (cnt_q == CW'(COUNT - 1)) begin
                        state_q <= PCW_ARMED;
                    end else begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                PCW_ARMED: begin
                    state_q <= PCW_ARMED;
                end
                default: begin
                    state_q <= PCW_OFF;
                end
            endcase
        end
    end
    assign armed = (state_q == PCW_ARMED);
endmodule : pcw_arm_timer
`default_nettype wire

// File: logic/pcw_config_regs.sv
// Wake, power and signal-quality configuration registers of one PHY port
//
// Function
// - Remote wake forwarded only while forwarding enabled
// - Bit 1 enables autonomous power-down, reset 0
// - Bit 0 enables sleep request on low-power signalling
// - Local wake detection arms after activation time
// - Strap-dependent fields reset from strap pins
// - Bits 15:11 read-only five-bit port address
// - Address: top zero, straps, port index
// - Bits 10:9 choose averaging 32 to 256
// - Bits 8:6 warning class, default 001
// - Bits 5:3 fail class, default none
// - Fail codes 010-111 select classes B-G
// - Latch warning when quality below limit, link up
`timescale 1ns/100ps
`default_nettype none
module pcw_config_regs #(
    parameter logic PORT_INDEX = 1'b0, // 0 first_port, 1 second_port
    parameter int WAKE_ACT_COUNT = pcw_pkg::WAKE_ACT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] strap_addr, // Port address straps
    input wire logic [3:0] strap_wake_cfg, // Loc fwd, rem react, loc react, rem fwd
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic remote_wake_event,
    input wire logic local_wake_event,
    input wire logic low_power_signalling,
    input wire logic normal_mode,
    input wire logic link_up,
    input wire logic [2:0] signal_quality_index,
    input wire logic quality_flag_clear,
    output logic remote_wake_detect,
    output logic remote_wake_forward,
    output logic local_wake_detect,
    output logic local_wake_forward,
    output logic sleep_request,
    output logic autonomous_powerdown,
    output logic [4:0] port_address,
    output logic [8:0] average_symbols,
    output logic [2:0] warning_class,
    output logic [2:0] fail_class,
    output logic quality_warning_flag,
    output logic quality_fail_flag
);
    import pcw_pkg::*;
    // ==========================================================
    // Configuration state
    logic local_wake_forward_en_q;
    logic remote_wake_react_en_q;
    logic local_wake_react_en_q;
    logic remote_wake_forward_en_q;
    logic autonomous_powerdown_en_q;
    logic lowpower_signal_sleep_en_q;
    logic [1:0] quality_average_depth_q;
    logic [2:0] quality_warning_class_q;
    logic [2:0] quality_fail_class_q;
    logic [4:0] port_address_q;
    logic wpc_wr; // Write strobe for wake_power_config
    logic aqc_wr; // Write strobe for address_quality_config
    logic [15:0] wpc_word; // Read image of wake_power_config
    logic [15:0] aqc_word; // Read image of address_quality_config
    logic wake_armed; // Local detection effective
    logic warn_set; // Warning condition this cycle
    logic fail_set; // Fail condition this cycle
    assign wpc_wr = reg_wr && (reg_addr == WPC_ADDR);
    assign aqc_wr = reg_wr && (reg_addr == AQC_ADDR);
    // ==========================================================
    // Wake and power fields; strap values caught while reset is held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            local_wake_forward_en_q <= strap_wake_cfg[3];
            remote_wake_react_en_q <= strap_wake_cfg[2];
            local_wake_react_en_q <= strap_wake_cfg[1];
            remote_wake_forward_en_q <= strap_wake_cfg[0];
            autonomous_powerdown_en_q <= PWD_RST;
            lowpower_signal_sleep_en_q <= SLEEP_EN_RST;
        end else if (wpc_wr) begin
            local_wake_forward_en_q <= reg_wdata[WPC_LOC_FWD_BIT];
            remote_wake_react_en_q <= reg_wdata[WPC_REM_REACT_BIT];
            local_wake_react_en_q <= reg_wdata[WPC_LOC_REACT_BIT];
            remote_wake_forward_en_q <= reg_wdata[WPC_REM_FWD_BIT];
            autonomous_powerdown_en_q <= reg_wdata[WPC_PWD_BIT];
            lowpower_signal_sleep_en_q <= reg_wdata[WPC_SLEEP_BIT];
        end
    end
    // ==========================================================
    // Quality fields; all class codes are stored as written
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            quality_average_depth_q <= AVG_RST;
            quality_warning_class_q <= WARN_RST;
            quality_fail_class_q <= FAIL_RST;
        end else if (aqc_wr) begin
            quality_average_depth_q <= reg_wdata[AQC_AVG_MSB:AQC_AVG_LSB];
            quality_warning_class_q <= reg_wdata[AQC_WARN_MSB:AQC_WARN_LSB];
            quality_fail_class_q <= reg_wdata[AQC_FAIL_MSB:AQC_FAIL_LSB];
        end
    end
    // Port address fixed at reset; writes never reach it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            port_address_q <= {1'b0, strap_addr, PORT_INDEX};
        end
    end
    // ==========================================================
    // Read images; unused bits read as zero
    always_comb begin
        wpc_word = 16'h0000;
        wpc_word[WPC_LOC_FWD_BIT] = local_wake_forward_en_q;
        wpc_word[WPC_REM_REACT_BIT] = remote_wake_react_en_q;
        wpc_word[WPC_LOC_REACT_BIT] = local_wake_react_en_q;
        wpc_word[WPC_REM_FWD_BIT] = remote_wake_forward_en_q;
        wpc_word[WPC_PWD_BIT] = autonomous_powerdown_en_q;
        wpc_word[WPC_SLEEP_BIT] = lowpower_signal_sleep_en_q;
        aqc_word = 16'h0000;
        aqc_word[AQC_PA_MSB:AQC_PA_LSB] = port_address_q;
        aqc_word[AQC_AVG_MSB:AQC_AVG_LSB] = quality_average_depth_q;
        aqc_word[AQC_WARN_MSB:AQC_WARN_LSB] = quality_warning_class_q;
        aqc_word[AQC_FAIL_MSB:AQC_FAIL_LSB] = quality_fail_class_q;
    end
    // Read port answers one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    WPC_ADDR: reg_rdata <= wpc_word;
                    AQC_ADDR: reg_rdata <= aqc_word;
                    default: reg_rdata <= UNMAPPED_DATA;
                endcase
            end
        end
    end
    // ==========================================================
    // Local wake arming; early wakes are dropped, a known limitation
    pcw_arm_timer #(
        .COUNT(WAKE_ACT_COUNT)
    ) u_arm (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(local_wake_react_en_q),
        .armed(wake_armed)
    );
    // Wake events gated by their enables; unused features stay quiet
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            remote_wake_detect <= 1'b0;
            remote_wake_forward <= 1'b0;
            local_wake_detect <= 1'b0;
            local_wake_forward <= 1'b0;
        end else begin
            remote_wake_detect <= remote_wake_event && remote_wake_react_en_q;
            remote_wake_forward <= remote_wake_event && remote_wake_forward_en_q;
            local_wake_detect <= local_wake_event && wake_armed;
            local_wake_forward <= local_wake_event && wake_armed
                && local_wake_forward_en_q;
        end
    end
    // Power mode requests and config outputs, all registered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sleep_request <= 1'b0;
            autonomous_powerdown <= PWD_RST;
            port_address <= 5'h00;
            average_symbols <= AVG_BASE_SYMBOLS;
            warning_class <= WARN_RST;
            fail_class <= FAIL_RST;
        end else begin
            sleep_request <= low_power_signalling && normal_mode
                && lowpower_signal_sleep_en_q;
            autonomous_powerdown <= autonomous_powerdown_en_q;
            port_address <= port_address_q;
            average_symbols <= AVG_BASE_SYMBOLS << quality_average_depth_q;
            warning_class <= quality_warning_class_q;
            fail_class <= quality_fail_class_q;
        end
    end
    // ==========================================================
    // Quality flags; a set in the clear cycle wins
    assign warn_set = link_up && (quality_warning_class_q != NO_LIMIT)
        && (signal_quality_index < quality_warning_class_q);
    assign fail_set = link_up && (quality_fail_class_q != NO_LIMIT)
        && (signal_quality_index < quality_fail_class_q);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            quality_warning_flag <= 1'b0;
            quality_fail_flag <= 1'b0;
        end else begin
            if (warn_set) begin
                quality_warning_flag <= 1'b1;
            end else if (quality_flag_clear) begin
                quality_warning_flag <= 1'b0;
            end
            if (fail_set) begin
                quality_fail_flag <= 1'b1;
            end else if (quality_flag_clear) begin
                quality_fail_flag <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_aqc_write;
        reg_wr && (reg_addr == AQC_ADDR);
    endsequence
    sequence s_aqc_read;
        reg_rd && !reg_wr && (reg_addr == AQC_ADDR);
    endsequence
    // Two idle write cycles between the write and its readback
    sequence s_aqc_gap;
        !reg_wr [*2];
    endsequence
    remote_fwd_on_a: assert property (remote_wake_event && remote_wake_forward_en_q
        |=> remote_wake_forward) else $error("remote wake not forwarded");
    remote_fwd_off_a: assert property (!remote_wake_forward_en_q
        |=> !remote_wake_forward) else $error("remote wake forwarded while disabled");
    powerdown_write_a: assert property (reg_wr && (reg_addr == WPC_ADDR)
        |=> ##1 autonomous_powerdown == $past(reg_wdata[WPC_PWD_BIT], 2))
        else $error("power-down enable does not follow write");
    sleep_req_a: assert property (sleep_request
        |-> $past(low_power_signalling && normal_mode && lowpower_signal_sleep_en_q))
        else $error("sleep request without cause");
    wake_arming_a: assert property ($rose(local_wake_react_en_q)
        |-> !local_wake_detect [*3]) else $error("local wake seen before activation");
    addr_fixed_a: assert property (!$past(rst) |-> $stable(port_address_q)
        && port_address_q[4] == 1'b0 && port_address_q[0] == PORT_INDEX)
        else $error("port address changed or malformed");
    avg_map_a: assert property (!$past(rst) && $stable(quality_average_depth_q)
        |-> average_symbols == (AVG_BASE_SYMBOLS << quality_average_depth_q))
        else $error("averaging depth mismatch");
    warn_latch_a: assert property (warn_set |=> quality_warning_flag [*1]
        ##0 (quality_warning_flag || $past(quality_flag_clear)))
        else $error("warning flag not latched");
    aqc_readback_a: assert property (s_aqc_write ##1 s_aqc_gap ##1 s_aqc_read
        |=> reg_rvalid && reg_rdata[10:3] == $past(reg_wdata[10:3], 4))
        else $error("quality config readback mismatch");
endmodule : pcw_config_regs
`default_nettype wire

// File: verification/pcw_host_model.sv
// Management host model that drives the config bank's parallel access port
`timescale 1ns/100ps
`default_nettype none
module pcw_host (
    input wire logic sys_clk,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    import pcw_pkg::*;
    // ==========================================================
    // Idle bus at time zero
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // Write: strobe held through exactly one rising edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // Released data must not look valid
    endtask : wr
    // Read: one strobe, then a bounded wait for the answer pulse
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        // Answer pulse stands only until the next edge, so look before waiting
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end else begin
                @(negedge sys_clk);
            end
        end
    endtask : rd
    // All four wake and forward enables are switched off by the host; keep sets only the other bits
    task automatic clear_unused(input logic [15:0] keep);
        wr(WPC_ADDR, keep & ~16'h4C04);
    endtask : clear_unused
endmodule : pcw_host
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the wake, power and signal-quality config bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pcw_pkg::*;
    localparam int ACT = 8; // Short activation count keeps the run brief
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap_addr, signal_quality_index, sa, warning_class, fail_class;
    logic [3:0] strap_wake_cfg, sw;
    logic [4:0] reg_addr, port_address;
    logic reg_wr, reg_rd, reg_rvalid, ok;
    logic [15:0] reg_wdata, reg_rdata, d, rv;
    logic remote_wake_event, local_wake_event, low_power_signalling, normal_mode;
    logic link_up, quality_flag_clear, remote_wake_detect, remote_wake_forward;
    logic local_wake_detect, local_wake_forward, sleep_request, autonomous_powerdown;
    logic quality_warning_flag, quality_fail_flag;
    logic [8:0] average_symbols;
    int error_cnt = 0;
    int n_tests = 0;
    // ==========================================================
    // Clock, design and host
    always #12.5 sys_clk = ~sys_clk;
    pcw_config_regs #(.PORT_INDEX(1'b1), .WAKE_ACT_COUNT(ACT)) DUT (
        .sys_clk, .rst, .strap_addr, .strap_wake_cfg, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid, .remote_wake_event, .local_wake_event,
        .low_power_signalling, .normal_mode, .link_up, .signal_quality_index,
        .quality_flag_clear,
        .remote_wake_detect, .remote_wake_forward, .local_wake_detect,
        .local_wake_forward, .sleep_request, .autonomous_powerdown, .port_address,
        .average_symbols, .warning_class, .fail_class, .quality_warning_flag,
        .quality_fail_flag);
    pcw_host host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    // ==========================================================
    // Checking helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("errors=%0d comparisons=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Read through the host; a missing answer ends the run
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
        host.rd(a, rv, ok);
        if (!ok) begin
            error_cnt++;
            test_done();
        end
        check(rv, exp);
    endtask : rdc
    // Expected reset image of the wake/power register
    function automatic logic [15:0] exp_wpc(input logic [3:0] s);
        return {1'b0, s[3], 2'b00, s[2], s[1], 7'h00, s[0], 2'b01};
    endfunction : exp_wpc
    // Hard bound on the whole run
    initial begin
        #(25 * 60000);
        error_cnt++;
        test_done();
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(6902));
        sa = $urandom;
        sw = $urandom;
        strap_addr = sa;
        strap_wake_cfg = sw;
        {remote_wake_event, local_wake_event, low_power_signalling, normal_mode} = 4'h0;
        {link_up, quality_flag_clear} = 2'b00;
        signal_quality_index = 3'h0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        // Reset values, straps included
        check(autonomous_powerdown, 0);
        check(port_address, {1'b0, sa, 1'b1});
        check(average_symbols, 9'h040);
        check(warning_class, 3'h1);
        check(fail_class, 3'h0);
        rdc(WPC_ADDR, exp_wpc(sw));
        rdc(AQC_ADDR, {1'b0, sa, 1'b1, 2'h1, 3'h1, 3'h0, 3'h0});
        // Every averaging and class code; address field must not move
        for (int c = 0; c < 8; c++) begin
            d = $urandom;
            d[10:9] = c[1:0];
            d[8:6] = c[2:0];
            d[5:3] = ~c[2:0];
            host.wr(AQC_ADDR, d);
            @(negedge sys_clk);
            check(average_symbols, AVG_BASE_SYMBOLS << d[10:9]);
            check(warning_class, d[8:6]);
            check(fail_class, d[5:3]);
            rdc(AQC_ADDR, {1'b0, sa, 1'b1, d[10:3], 3'h0});
        end
        // Unmapped offset: write ignored, reads zero
        host.wr(5'h14, 16'hFFFF);
        rdc(5'h14, UNMAPPED_DATA);
        // Random words to the wake/power register
        repeat (6) begin
            d = $urandom;
            host.wr(WPC_ADDR, d);
            @(negedge sys_clk);
            check(autonomous_powerdown, d[1]);
            rdc(WPC_ADDR, d & 16'h4C07);
        end
        // Remote forwarding and sleep request, both settings
        for (int e = 0; e < 2; e++) begin
            host.wr(WPC_ADDR, {4'h0, 1'b1, 8'h00, e[0], 1'b0, e[0]});
            {remote_wake_event, low_power_signalling, normal_mode} = 3'h7;
            @(negedge sys_clk);
            check(remote_wake_forward, e[0]);
            check(remote_wake_detect, 1);
            check(sleep_request, e[0]);
            {remote_wake_event, low_power_signalling} = 2'b00;
            @(negedge sys_clk);
            check(remote_wake_forward, 0);
        end
        // Local wake is blind until the activation time has passed
        host.wr(WPC_ADDR, 16'h0000);
        host.wr(WPC_ADDR, 16'h4400);
        local_wake_event = 1'b1;
        @(negedge sys_clk);
        check(local_wake_detect, 0);
        // Armed ACT cycles after the edge that follows the enable write
        repeat (ACT) @(negedge sys_clk);
        check(local_wake_detect, 0);
        @(negedge sys_clk);
        check(local_wake_detect, 1);
        check(local_wake_forward, 1);
        local_wake_event = 1'b0;
        host.clear_unused(16'h4401);
        local_wake_event = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(local_wake_detect, 0);
        local_wake_event = 1'b0;
        // Quality flags: warning class D, fail class B
        host.wr(AQC_ADDR, {5'h00, 2'h1, 3'h4, 3'h2, 3'h0});
        link_up = 1'b1;
        signal_quality_index = 3'h3;
        repeat (2) @(negedge sys_clk);
        check(quality_warning_flag, 1);
        check(quality_fail_flag, 0);
        signal_quality_index = 3'h1;
        repeat (2) @(negedge sys_clk);
        check(quality_fail_flag, 1);
        signal_quality_index = 3'h7;
        quality_flag_clear = 1'b1;
        @(negedge sys_clk);
        quality_flag_clear = 1'b0;
        @(negedge sys_clk);
        check(quality_warning_flag, 0);
        check(quality_fail_flag, 0);
        link_up = 1'b0;
        signal_quality_index = 3'h0;
        repeat (2) @(negedge sys_clk);
        check(quality_warning_flag, 0);
        // Set and clear in one cycle: the set wins
        link_up = 1'b1;
        quality_flag_clear = 1'b1;
        @(negedge sys_clk);
        quality_flag_clear = 1'b0;
        link_up = 1'b0;
        @(negedge sys_clk);
        check(quality_warning_flag, 1);
        check(quality_fail_flag, 1);
        test_done();
    end
endmodule : tb
`default_nettype wire
